// >>> pkg/fadm_params.svh
`ifndef FADM_PARAMS_SVH
`define FADM_PARAMS_SVH

// Register offsets
`define FADM_REG_BANK 8'h00
`define FADM_REG_STAT2 8'h01
`define FADM_REG_LAYOUT 8'h02
`define FADM_REG_ADDR0 8'h04
`define FADM_REG_ADDR1 8'h05
`define FADM_REG_ADDR2 8'h06
`define FADM_REG_ADDR3 8'h07
`define FADM_REG_SECT_LO 8'h08
`define FADM_REG_SECT_HI 8'h09
`define FADM_REG_TARGET0 8'h0c
`define FADM_REG_TARGET1 8'h0d
`define FADM_REG_TARGET2 8'h0e

// Field positions
`define FADM_BANK_EXT_BIT 7
`define FADM_BANK_HI 6
`define FADM_STAT2_UNIFORM_BIT 7
`define FADM_LAYOUT_TOP_BIT 0

// Reset values
`define FADM_BANK_RESET 8'h00
`define FADM_STAT2_RESET 1'b0
`define FADM_LAYOUT_RESET 1'b0

// Address byte counts
`define FADM_SHORT_BYTES 3'h3
`define FADM_LONG_BYTES 3'h4

// Sector map constants
`define FADM_SMALL_COUNT 9'h010
`define FADM_LARGE_COUNT 9'h0ff
`define FADM_LAST_SECTOR 9'h10e
`define FADM_UNIFORM_COUNT 9'h040
`define FADM_BOTTOM_REGION 8'h00
`define FADM_TOP_REGION 8'hff

`endif

// >>> pkg/fadm_pkg.sv
package fadm_pkg;

    typedef enum logic [1:0] {
        FADM_IDLE = 2'h0,
        FADM_COLLECT = 2'h1,
        FADM_DONE = 2'h3
    } fadm_state_t;

    typedef enum logic [1:0] {
        FADM_KIND_LEGACY = 2'h0,
        FADM_KIND_LONG = 2'h1,
        FADM_KIND_OTHER = 2'h2
    } fadm_kind_t;

    typedef enum logic [1:0] {
        FADM_SIZE_4K = 2'h0,
        FADM_SIZE_64K = 2'h1,
        FADM_SIZE_256K = 2'h2
    } fadm_size_t;

    typedef struct packed {
        fadm_kind_t kind;
        logic erase;
    } fadm_cmd_t;

    typedef struct packed {
        logic [8:0] index;
        logic [23:0] base;
        fadm_size_t size;
    } fadm_sector_t;

    typedef struct packed {
        logic [31:0] full;
        logic [23:0] target;
        logic [8:0] sector;
        fadm_size_t size;
        logic other;
        logic erase;
        logic short_addr;
    } fadm_result_t;

endpackage

// >>> rtl/fadm_decode.sv
// How it works
// - Legacy commands take 3 address bytes; 4-byte addresses only in extended-address mode.
// - A 3-byte address gets its upper bits from the bank address register.
// - Extended-address mode bit set makes legacy commands take 4 address bytes.
// - Newer command variants always take 4 address bytes.
// - Reset clears the bank register, selecting 3-byte addressing.
// - Address bits 31 to 24 never affect main array location.
// - Commands for other address spaces always take 4 address bytes.
// - Uniform-sector bit 7 of the second status register picks the layout.
// - Bottom layout: sixteen 4 KB sectors at zero, then 255 of 64 KB.
// - Top layout: 255 sectors of 64 KB, then sixteen 4 KB at 00FF0000h.
// - Uniform layout: 64 sectors of 256 KB from zero.
// - Every sector is aligned to its own size.
//
// Local design decisions: the strobed register port and the address map.
`include "fadm_params.svh"

module fadm_decode #(
    parameter int REG_AW = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cmd_start,
    input fadm_pkg::fadm_cmd_t cmd,
    input wire logic addr_valid,
    input wire logic [7:0] addr_byte,
    output logic busy,
    output logic ext_mode,
    output logic addr_done,
    output fadm_pkg::fadm_result_t result
);

    function automatic fadm_pkg::fadm_sector_t locate(
        input logic [23:0] a,
        input logic uniform,
        input logic top
    );
        fadm_pkg::fadm_sector_t s;
        s = '0;
        if (uniform)
        begin
            s.index = {3'h0, a[23:18]};
            s.base = {a[23:18], 18'h0};
            s.size = fadm_pkg::FADM_SIZE_256K;
        end
        else if (!top && a[23:16] == `FADM_BOTTOM_REGION)
        begin
            s.index = {5'h0, a[15:12]};
            s.base = {a[23:12], 12'h0};
            s.size = fadm_pkg::FADM_SIZE_4K;
        end
        else if (!top)
        begin
            s.index = `FADM_SMALL_COUNT + {1'b0, a[23:16]} - 9'h001;
            s.base = {a[23:16], 16'h0};
            s.size = fadm_pkg::FADM_SIZE_64K;
        end
        else if (a[23:16] == `FADM_TOP_REGION)
        begin
            s.index = `FADM_LARGE_COUNT + {5'h0, a[15:12]};
            s.base = {a[23:12], 12'h0};
            s.size = fadm_pkg::FADM_SIZE_4K;
        end
        else
        begin
            s.index = {1'b0, a[23:16]};
            s.base = {a[23:16], 16'h0};
            s.size = fadm_pkg::FADM_SIZE_64K;
        end
        return s;
    endfunction

    // Register file
    logic [7:0] bank;
    logic uniform_sector_select;
    logic layout_top;
    logic [7:0] next_bank;
    logic next_uniform;
    logic next_top;
    logic [7:0] next_rdata;

    always_comb
    begin
        next_bank = bank;
        next_uniform = uniform_sector_select;
        next_top = layout_top;
        next_rdata = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr[7:0])
                `FADM_REG_BANK: next_bank = reg_wdata;
                `FADM_REG_STAT2: next_uniform = reg_wdata[`FADM_STAT2_UNIFORM_BIT];
                `FADM_REG_LAYOUT: next_top = reg_wdata[`FADM_LAYOUT_TOP_BIT];
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr[7:0])
                `FADM_REG_BANK: next_rdata = bank;
                `FADM_REG_STAT2: next_rdata = {uniform_sector_select, 7'h00};
                `FADM_REG_LAYOUT: next_rdata = {7'h00, layout_top};
                `FADM_REG_ADDR0: next_rdata = result.full[7:0];
                `FADM_REG_ADDR1: next_rdata = result.full[15:8];
                `FADM_REG_ADDR2: next_rdata = result.full[23:16];
                `FADM_REG_ADDR3: next_rdata = result.full[31:24];
                `FADM_REG_SECT_LO: next_rdata = result.sector[7:0];
                `FADM_REG_SECT_HI: next_rdata = {7'h00, result.sector[8]};
                `FADM_REG_TARGET0: next_rdata = result.target[7:0];
                `FADM_REG_TARGET1: next_rdata = result.target[15:8];
                `FADM_REG_TARGET2: next_rdata = result.target[23:16];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bank <= `FADM_BANK_RESET;
            uniform_sector_select <= `FADM_STAT2_RESET;
            layout_top <= `FADM_LAYOUT_RESET;
            reg_rdata <= 8'h00;
        end
        else if (ce)
        begin
            bank <= next_bank;
            uniform_sector_select <= next_uniform;
            layout_top <= next_top;
            reg_rdata <= next_rdata;
        end
    end

    // Address collection
    fadm_pkg::fadm_state_t state;
    fadm_pkg::fadm_state_t next_state;
    logic [2:0] count;
    logic [2:0] need;
    logic [31:0] shreg;
    logic [6:0] bank_used;
    fadm_pkg::fadm_cmd_t cmd_held;
    logic [2:0] next_count;
    logic [2:0] next_need;
    logic [31:0] next_shreg;
    logic [6:0] next_bank_used;
    fadm_pkg::fadm_cmd_t next_cmd_held;
    logic next_addr_done;
    logic next_busy;
    fadm_pkg::fadm_result_t next_result;
    fadm_pkg::fadm_sector_t sect;
    logic [31:0] full_addr;
    logic [2:0] count_inc;

    assign ext_mode = bank[`FADM_BANK_EXT_BIT];
    assign count_inc = count + 3'h1;

    always_comb
    begin
        // Short form never carries bit 31
        full_addr = (need == `FADM_SHORT_BYTES) ? {1'b0, bank_used, shreg[23:0]} : shreg;
        // Upper byte dropped before mapping
        sect = locate(full_addr[23:0], uniform_sector_select, layout_top);
    end

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_need = need;
        next_shreg = shreg;
        next_bank_used = bank_used;
        next_cmd_held = cmd_held;
        next_addr_done = 1'b0;
        next_result = result;
        unique case (state)
            fadm_pkg::FADM_IDLE:
            begin
                if (cmd_start)
                begin
                    next_state = fadm_pkg::FADM_COLLECT;
                    next_count = 3'h0;
                    next_shreg = 32'h0;
                    next_cmd_held = cmd;
                    // Bank sampled once so mid-command writes cannot split an address
                    next_bank_used = bank[`FADM_BANK_HI:0];
                    if (cmd.kind == fadm_pkg::FADM_KIND_LEGACY && !bank[`FADM_BANK_EXT_BIT])
                        next_need = `FADM_SHORT_BYTES;
                    else
                        next_need = `FADM_LONG_BYTES;
                end
            end
            fadm_pkg::FADM_COLLECT:
            begin
                if (addr_valid)
                begin
                    next_shreg = {shreg[23:0], addr_byte};
                    next_count = count_inc;
                    if (count_inc == need)
                        next_state = fadm_pkg::FADM_DONE;
                end
            end
            fadm_pkg::FADM_DONE:
            begin
                next_state = fadm_pkg::FADM_IDLE;
                next_addr_done = 1'b1;
                next_result.full = full_addr;
                next_result.other = (cmd_held.kind == fadm_pkg::FADM_KIND_OTHER);
                next_result.erase = cmd_held.erase;
                next_result.short_addr = (need == `FADM_SHORT_BYTES);
                next_result.sector = sect.index;
                next_result.size = sect.size;
                // Erase acts on the whole containing sector
                next_result.target = cmd_held.erase ? sect.base : full_addr[23:0];
            end
            default: next_state = fadm_pkg::FADM_IDLE;
        endcase
        next_busy = (next_state != fadm_pkg::FADM_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= fadm_pkg::FADM_IDLE;
            count <= 3'h0;
            need <= `FADM_SHORT_BYTES;
            shreg <= 32'h0;
            bank_used <= 7'h00;
            cmd_held <= '0;
            addr_done <= 1'b0;
            busy <= 1'b0;
            result <= '0;
        end
        else if (ce)
        begin
            state <= next_state;
            count <= next_count;
            need <= next_need;
            shreg <= next_shreg;
            bank_used <= next_bank_used;
            cmd_held <= next_cmd_held;
            addr_done <= next_addr_done;
            busy <= next_busy;
            result <= next_result;
        end
    end

    sequence s_legacy_short;
        ce && state == fadm_pkg::FADM_IDLE && cmd_start && cmd.kind == fadm_pkg::FADM_KIND_LEGACY && !ext_mode;
    endsequence

    sequence s_long_start;
        ce && state == fadm_pkg::FADM_IDLE && cmd_start && (cmd.kind != fadm_pkg::FADM_KIND_LEGACY || ext_mode);
    endsequence

    sequence s_last_byte;
        ce && state == fadm_pkg::FADM_COLLECT && addr_valid && count_inc == need;
    endsequence

    a_reset_bank: assert property (@(posedge clk) $rose(rst_b) |-> bank == `FADM_BANK_RESET && !ext_mode)
        else $error("bank register not cleared by reset");
    a_short_count: assert property (@(posedge clk) disable iff (!rst_b) s_legacy_short |=> need == `FADM_SHORT_BYTES)
        else $error("legacy command without extended mode must take three bytes");
    a_long_count: assert property (@(posedge clk) disable iff (!rst_b) s_long_start |=> need == `FADM_LONG_BYTES)
        else $error("four address bytes expected");
    a_done_pulse: assert property (@(posedge clk) disable iff (!rst_b) s_last_byte ##1 ce |=> addr_done && !busy)
        else $error("address completion not reported two cycles after last byte");
    a_bank_upper: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done && result.short_addr |-> result.full[31:24] == {1'b0, bank_used})
        else $error("short address upper byte not from bank register");
    a_sector_range: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done |-> result.sector <= `FADM_LAST_SECTOR)
        else $error("sector number beyond array");
    a_uniform_pick: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done |-> (result.size == fadm_pkg::FADM_SIZE_256K) == $past(uniform_sector_select))
        else $error("layout does not follow uniform-sector bit");
    a_uniform_count: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done && result.size == fadm_pkg::FADM_SIZE_256K |-> result.sector < `FADM_UNIFORM_COUNT)
        else $error("uniform sector number out of range");
    a_bottom_small: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done && result.size == fadm_pkg::FADM_SIZE_4K && result.sector < 9'h010
        |-> result.full[23:16] == 8'h00 && result.sector == {5'h0, result.full[15:12]})
        else $error("bottom small sector misplaced");
    a_top_small: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done && result.size == fadm_pkg::FADM_SIZE_4K && result.sector >= 9'h0ff
        |-> result.full[23:16] == 8'hff)
        else $error("top small sector misplaced");
    a_erase_align: assert property (@(posedge clk) disable iff (!rst_b)
        addr_done && result.erase |-> result.target[11:0] == 12'h000
        && (result.size == fadm_pkg::FADM_SIZE_4K || result.target[15:12] == 4'h0)
        && (result.size != fadm_pkg::FADM_SIZE_256K || result.target[17:16] == 2'h0))
        else $error("erase target not aligned to its sector");

endmodule // fadm_decode

// >>> tb/fadm_host.sv
module fadm_host (
    input wire logic clk,
    output logic cmd_start,
    output fadm_pkg::fadm_cmd_t cmd,
    output logic addr_valid,
    output logic [7:0] addr_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // Shared reset line parked high; the block has no reset pin to watch
    logic io_line_three;

    initial
    begin
        io_line_three = 1'b1;
        cmd_start = 1'b0;
        cmd = '0;
        addr_valid = 1'b0;
        addr_byte = 8'h5a;
    end

    // Called just after a rising edge; returns just after the edge taking the last byte
    task automatic send(input fadm_pkg::fadm_kind_t kind, input logic erase, input logic [31:0] a,
                        input int nb, input int gap);
        cmd_start <= 1'b1;
        cmd <= '{kind: kind, erase: erase};
        @(posedge clk);
        cmd_start <= 1'b0;
        for (int i = nb - 1; i >= 0; i--)
        begin
            addr_valid <= 1'b1;
            addr_byte <= a[i*8 +: 8];
            @(posedge clk);
            // Undriven byte lane shows junk, not the last value
            if (gap > 0 || i == 0)
            begin
                addr_valid <= 1'b0;
                addr_byte <= ~a[i*8 +: 8];
                // No gap after the last byte, or the completion pulse is missed
                if (i > 0)
                    repeat (gap) @(posedge clk);
            end
        end
    endtask
endmodule // fadm_host

// >>> tb/tb.sv
`include "fadm_params.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic cmd_start;
    fadm_pkg::fadm_cmd_t cmd;
    logic addr_valid;
    logic [7:0] addr_byte;
    logic busy;
    logic ext_mode;
    logic addr_done;
    fadm_pkg::fadm_result_t result;
    int failures = 0;
    int checks = 0;

    always #20 clk = ~clk;

    fadm_decode fadm_decode_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_start(cmd_start), .cmd(cmd), .addr_valid(addr_valid), .addr_byte(addr_byte),
        .busy(busy), .ext_mode(ext_mode), .addr_done(addr_done), .result(result));

    fadm_host fadm_host_inst (.clk(clk), .cmd_start(cmd_start), .cmd(cmd),
        .addr_valid(addr_valid), .addr_byte(addr_byte));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Idle edge so a following strobe never lands in the same step
        @(posedge clk);
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({24'h0, reg_rdata}, {24'h0, exp});
        @(posedge clk);
    endtask

    task automatic run(input fadm_pkg::fadm_kind_t kind, input logic erase, input logic [31:0] a,
                       input int nb, input int gap, input logic [23:0] e_tgt, input logic [8:0] e_sec,
                       input fadm_pkg::fadm_size_t e_size, input logic e_short);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        fadm_host_inst.send(kind, erase, a, nb, gap);
        #1 chk({31'h0, busy}, 32'h1);
        while (!seen && n < 20)
        begin
            @(posedge clk);
            n++;
            #1 seen = (addr_done === 1'b1);
        end
        if (!seen)
        begin
            $display("MISMATCH at %0t: no completion", $time);
            failures++;
            summarize();
        end
        else
        begin
            chk({31'h0, busy}, 32'h0);
            chk(result.full, a);
            chk({8'h0, result.target}, {8'h0, e_tgt});
            chk({31'h0, result.short_addr}, {31'h0, e_short});
            chk({31'h0, result.erase}, {31'h0, erase});
            chk({31'h0, result.other}, {31'h0, kind == fadm_pkg::FADM_KIND_OTHER});
            if (kind != fadm_pkg::FADM_KIND_OTHER)
            begin
                chk({23'h0, result.sector}, {23'h0, e_sec});
                chk({30'h0, result.size}, {30'h0, e_size});
            end
            @(posedge clk);
        end
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`FADM_REG_BANK, 8'h00);
        rd(`FADM_REG_STAT2, 8'h00);
        rd(`FADM_REG_LAYOUT, 8'h00);
        rd(8'h03, 8'h00);
        chk({31'h0, ext_mode}, 32'h0);
        $display("test reset_values done");
        wr(`FADM_REG_BANK, 8'h05);
        rd(`FADM_REG_BANK, 8'h05);
        run(fadm_pkg::FADM_KIND_LEGACY, 1'b0, 32'h0500f123, 3, 0, 24'h00f123, 9'h00f,
            fadm_pkg::FADM_SIZE_4K, 1'b1);
        run(fadm_pkg::FADM_KIND_LEGACY, 1'b1, 32'h05012345, 3, 2, 24'h010000, 9'h010,
            fadm_pkg::FADM_SIZE_64K, 1'b1);
        $display("test bottom_layout done");
        wr(`FADM_REG_LAYOUT, 8'h01);
        wr(`FADM_REG_BANK, 8'h80);
        chk({31'h0, ext_mode}, 32'h1);
        run(fadm_pkg::FADM_KIND_LEGACY, 1'b1, 32'habfff010, 4, 0, 24'hfff000, 9'h10e,
            fadm_pkg::FADM_SIZE_4K, 1'b0);
        rd(`FADM_REG_SECT_HI, 8'h01);
        run(fadm_pkg::FADM_KIND_LEGACY, 1'b1, 32'h00fe8000, 4, 1, 24'hfe0000, 9'h0fe,
            fadm_pkg::FADM_SIZE_64K, 1'b0);
        $display("test top_layout done");
        wr(`FADM_REG_BANK, 8'h00);
        wr(`FADM_REG_STAT2, 8'h80);
        run(fadm_pkg::FADM_KIND_LONG, 1'b1, 32'h12fc1234, 4, 0, 24'hfc0000, 9'h03f,
            fadm_pkg::FADM_SIZE_256K, 1'b0);
        rd(`FADM_REG_SECT_LO, 8'h3f);
        rd(`FADM_REG_SECT_HI, 8'h00);
        rd(`FADM_REG_ADDR3, 8'h12);
        rd(`FADM_REG_ADDR0, 8'h34);
        rd(`FADM_REG_TARGET2, 8'hfc);
        rd(`FADM_REG_TARGET0, 8'h00);
        run(fadm_pkg::FADM_KIND_OTHER, 1'b0, 32'h00000010, 4, 1, 24'h000010, 9'h000,
            fadm_pkg::FADM_SIZE_256K, 1'b0);
        $display("test uniform_and_other done");
        wr(`FADM_REG_BANK, 8'h85);
        ce <= 1'b0;
        wr(`FADM_REG_BANK, 8'h33);
        ce <= 1'b1;
        rd(`FADM_REG_BANK, 8'h85);
        chk({31'h0, ext_mode}, 32'h1);
        $display("test clock_enable done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`FADM_REG_BANK, 8'h00);
        rd(`FADM_REG_STAT2, 8'h00);
        rd(`FADM_REG_LAYOUT, 8'h00);
        chk({31'h0, ext_mode}, 32'h0);
        $display("test second_reset done");
        summarize();
    end
endmodule // tb
